// [hw/pfm_params.svh]
// pfm_params.svh: offsets, fields, reset values and strap thresholds of the pin mux
// assumes: included by bare name from pin mux design files
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH
// register byte offsets
`define PFM_CTRL_OFS 8'h00
`define PFM_GPOUT_OFS 8'h04
`define PFM_GPIN_OFS 8'h08
`define PFM_ADDR_OFS 8'h0C
`define PFM_CFG_OFS 8'h10
`define PFM_PIN_BASE 8'h40
// pin config fields
`define PFM_PC_FUNC 2:0
`define PFM_PC_DIR 3
`define PFM_PC_OD 4
`define PFM_PC_PU 5
`define PFM_PC_PD 6
`define PFM_PC_LOCK 7
// loaded configuration command fields
`define PFM_CF_BASE 6:0
`define PFM_CF_OFS 13:7
`define PFM_CF_STRAP_EN 14
`define PFM_CF_LVL8 15
`define PFM_CF_TWO 16
`define PFM_CF_CURRENT_MONITOR_PIN 17
`define PFM_CF_RATE 19:18
`define PFM_CFG_CMD_CODE 8'hC9
`define PFM_PIN_RST 8'h00
`define PFM_NO_PIN 5'h1F
// strap thresholds in 10 ohm units, midway between table resistances
`define PFM_T16 {16'd4750, 16'd3410, 16'd2583, 16'd1983, 16'd1520, 16'd1170, 16'd910, 16'd703, \
    16'd538, 16'd411, 16'd311, 16'd236, 16'd176, 16'd130, 16'd94}
`define PFM_T8 {16'd3250, 16'd1400, 16'd840, 16'd535, 16'd330, 16'd225, 16'd150}
`define PFM_TOP16 4'h F
`define PFM_TOP8 4'h7
`endif

// [hw/pfm_pkg.sv]
// pfm_pkg: types of the pin function mux
// assumes: nothing
`default_nettype none
package pfm_pkg;
    typedef enum logic [3:0] {
        PFM_FN_NONE = 4'h0, PFM_FN_NATIVE = 4'h1, PFM_FN_GPA = 4'h2, PFM_FN_GPB = 4'h3,
        PFM_FN_SYNC = 4'h4, PFM_FN_FANA_PWM = 4'h5, PFM_FN_FANA_TACH = 4'h6, PFM_FN_FANB_PWM = 4'h7,
        PFM_FN_FANB_TACH = 4'h8, PFM_FN_AUXD = 4'h9, PFM_FN_AUXC = 4'hA, PFM_FN_URX = 4'hB,
        PFM_FN_UTX = 4'hC
    } pfm_fn_t;
    typedef enum logic [1:0] {
        PFM_ST_LOAD = 2'b00, PFM_ST_MEAS_A = 2'b01, PFM_ST_MEAS_B = 2'b11, PFM_ST_RUN = 2'b10
    } pfm_state_t;
    typedef enum logic [1:0] {
        PFM_RATE_100K = 2'b00, PFM_RATE_400K = 2'b01, PFM_RATE_1M = 2'b10
    } pfm_rate_t;
endpackage
`default_nettype wire

// [hw/pfm_strap_decode.sv]
// pfm_strap_decode: maps one digitized strap resistance to an address offset
// assumes: resistance arrives in 10 ohm units; open pin reads as a large value
`include "pfm_params.svh"
`default_nettype none
module pfm_strap_decode (
    input wire logic [15:0] res_i,
    input wire logic lvl8_i,
    output logic [3:0] offset_o
);
    localparam logic [15*16-1:0] T16 = `PFM_T16;
    localparam logic [7*16-1:0] T8 = `PFM_T8;
    logic [3:0] cnt;
    // count thresholds passed; higher resistance gives lower offset
    always_comb
    begin
        cnt = 4'h0;
        for (int i = 0; i < 15; i++)
        begin
            if (!lvl8_i && res_i >= T16[i*16 +: 16])
                cnt = cnt + 4'h1;
            if (lvl8_i && i < 7 && res_i >= T8[(i < 7 ? i : 0)*16 +: 16])
                cnt = cnt + 4'h1;
        end
        offset_o = (lvl8_i ? `PFM_TOP8 : `PFM_TOP16) - cnt;
    end
endmodule
`default_nettype wire

// [hw/pfm_pin_cell.sv]
// pfm_pin_cell: output value and driver enable of one multi-purpose pin
// assumes: peripheral sources are synchronous to the core clock
`default_nettype none
module pfm_pin_cell (
    input wire logic [3:0] fn_i,
    input wire logic [2:0] idx_i,
    input wire logic dir_i,
    input wire logic od_i,
    input wire logic [7:0] gpa_i,
    input wire logic [7:0] gpb_i,
    input wire logic native_out_i,
    input wire logic native_oe_i,
    input wire logic sync_out_i,
    input wire logic sync_oe_i,
    input wire logic fan_a_i,
    input wire logic fan_b_i,
    input wire logic auxd_oe_i,
    input wire logic auxc_oe_i,
    input wire logic tx_i,
    output logic out_o,
    output logic oe_o
);
    logic gp_val;
    // drive follows the class of the selected function
    always_comb
    begin
        gp_val = (fn_i == pfm_pkg::PFM_FN_GPA) ? gpa_i[idx_i] : gpb_i[idx_i];
        out_o = 1'b0;
        oe_o = 1'b0;
        unique case (pfm_pkg::pfm_fn_t'(fn_i))
            pfm_pkg::PFM_FN_NATIVE:
            begin
                out_o = native_out_i;
                oe_o = native_oe_i;
            end
            pfm_pkg::PFM_FN_GPA, pfm_pkg::PFM_FN_GPB:
            begin
                out_o = od_i ? 1'b0 : gp_val;
                oe_o = dir_i & (od_i ? ~gp_val : 1'b1);
            end
            pfm_pkg::PFM_FN_SYNC:
            begin
                out_o = sync_out_i;
                oe_o = sync_oe_i;
            end
            pfm_pkg::PFM_FN_FANA_PWM:
            begin
                out_o = fan_a_i;
                oe_o = 1'b1;
            end
            pfm_pkg::PFM_FN_FANB_PWM:
            begin
                out_o = fan_b_i;
                oe_o = 1'b1;
            end
            pfm_pkg::PFM_FN_AUXD: oe_o = auxd_oe_i; // open drain, peripheral pulls low
            pfm_pkg::PFM_FN_AUXC: oe_o = auxc_oe_i;
            pfm_pkg::PFM_FN_UTX:
            begin
                out_o = tx_i;
                oe_o = 1'b1;
            end
            default: oe_o = 1'b0; // input-only or unused codes never drive
        endcase
    end
endmodule
`default_nettype wire

// [hw/pfm_top.sv]
// pfm_top: multi-purpose pin function mux and serial-bus address select
// assumes: Avalon-MM master on clk_i; strap measurement engine answers strap requests
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////
`include "pfm_params.svh"
`default_nettype none
module pfm_top #(
    parameter int NPINS = 21
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic [NPINS-1:0] pin_in_i,
    output logic [NPINS-1:0] pin_out_o,
    output logic [NPINS-1:0] pin_oe_o,
    output logic [NPINS-1:0] pull_up_o,
    output logic [NPINS-1:0] pull_dn_o,
    input wire logic [NPINS-1:0] native_out_i,
    input wire logic [NPINS-1:0] native_oe_i,
    output logic [NPINS-1:0] native_in_o,
    output logic [7:0] gp_port_a_o,
    output logic [7:0] gp_port_b_o,
    input wire logic sync_out_i,
    input wire logic sync_oe_i,
    output logic sync_in_o,
    input wire logic fan_a_drive_i,
    input wire logic fan_b_drive_i,
    output logic fan_a_speed_in_o,
    output logic fan_b_speed_in_o,
    input wire logic aux_twowire_data_oe_i,
    input wire logic aux_twowire_clk_oe_i,
    output logic aux_twowire_data_o,
    output logic aux_twowire_clk_o,
    input wire logic serial_tx_out_i,
    output logic serial_rx_in_o,
    input wire logic [31:0] bus_firmware_config_cmd_i,
    output logic strap_req_o,
    output logic [1:0] strap_src_o,
    input wire logic strap_done_i,
    input wire logic [15:0] strap_res_i,
    output logic [6:0] dev_addr_o,
    output logic [1:0] bus_rate_o,
    output logic init_done_o
);
    ////////////////////////////////////////////////////////////////////////
    // function table: returns {function, gpio index} for a pin and code
    function automatic logic [6:0] fmap(input logic [4:0] p, input logic [2:0] c);
        logic [2:0] gi;
        logic [3:0] f;
        gi = 3'h0;
        f = pfm_pkg::PFM_FN_NONE;
        unique case (p)
            5'd0, 5'd1, 5'd8: gi = 3'h2;
            5'd2, 5'd9: gi = 3'h3;
            5'd3, 5'd14, 5'd15: gi = 3'h6;
            5'd4, 5'd6, 5'd18: gi = 3'h7;
            5'd5, 5'd12, 5'd13: gi = 3'h5;
            5'd7, 5'd17, 5'd20: gi = 3'h1;
            5'd10, 5'd11: gi = 3'h4;
            default: gi = 3'h0;
        endcase
        unique case (c)
            3'd0: f = (p == 5'd18) ? pfm_pkg::PFM_FN_NONE : pfm_pkg::PFM_FN_NATIVE;
            3'd1: f = pfm_pkg::PFM_FN_GPA;
            3'd2: f = pfm_pkg::PFM_FN_GPB;
            3'd3: f = pfm_pkg::PFM_FN_SYNC;
            3'd4:
            begin
                unique case (p)
                    5'd0, 5'd13: f = pfm_pkg::PFM_FN_FANB_PWM;
                    5'd1, 5'd14: f = pfm_pkg::PFM_FN_FANB_TACH;
                    5'd2, 5'd4: f = pfm_pkg::PFM_FN_FANA_TACH;
                    5'd3, 5'd18: f = pfm_pkg::PFM_FN_FANA_PWM;
                    5'd9, 5'd16: f = pfm_pkg::PFM_FN_URX;
                    5'd10, 5'd17: f = pfm_pkg::PFM_FN_UTX;
                    5'd15: f = pfm_pkg::PFM_FN_GPA;
                    default: f = pfm_pkg::PFM_FN_NONE;
                endcase
                if (p == 5'd15)
                    gi = 3'h7;
            end
            3'd5:
            begin
                unique case (p)
                    5'd0, 5'd16: f = pfm_pkg::PFM_FN_AUXD;
                    5'd1, 5'd17: f = pfm_pkg::PFM_FN_AUXC;
                    5'd15: f = pfm_pkg::PFM_FN_GPB;
                    default: f = pfm_pkg::PFM_FN_NONE;
                endcase
                if (p == 5'd15)
                    gi = 3'h7;
            end
            3'd6:
            begin
                if (p == 5'd0)
                    f = pfm_pkg::PFM_FN_URX;
                else if (p == 5'd1)
                    f = pfm_pkg::PFM_FN_UTX;
            end
            default: f = pfm_pkg::PFM_FN_NONE;
        endcase
        return {f, gi};
    endfunction

    // pin index of a pin config address, or none
    function automatic logic [4:0] pin_hit(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - `PFM_PIN_BASE;
        if (a >= `PFM_PIN_BASE && a[1:0] == 2'b00 && rel[7:2] < 6'(NPINS))
            return rel[6:2];
        return `PFM_NO_PIN;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic wait_q;
    logic [31:0] rdata_q;
    logic loop_q;
    logic [15:0] gpout_q;
    logic [15:0] gpin_q;
    logic [7:0] pcfg_q [NPINS];
    logic [31:0] cfg_q;
    logic [3:0] off_a_q;
    logic [3:0] off_b_q;
    logic [6:0] addr_q;
    pfm_pkg::pfm_state_t st_q;
    logic req_q;
    logic [1:0] src_q;
    logic [3:0] dec_off;
    logic take;
    logic wr_en;
    logic [4:0] wpin;
    logic [4:0] rpin;
    logic [3:0] fn [NPINS];
    logic [2:0] gidx [NPINS];
    logic [NPINS-1:0] cell_out;
    logic [NPINS-1:0] cell_oe;
    logic tx_pin;
    logic [15:0] gp_in_d;
    logic sync_d;
    logic tach_a_d;
    logic tach_b_d;
    logic auxd_d;
    logic auxc_d;
    logic rx_d;

    assign take = (read_i | write_i) & ~wait_q;
    assign wr_en = write_i & ~wait_q;
    assign wpin = pin_hit(address_i);
    assign rpin = wpin;
    assign tx_pin = loop_q ? 1'b1 : serial_tx_out_i; // idle line while looped back

    // bus answer: waitrequest drops one cycle after a request, for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wait_q <= 1'b1;
        else
            wait_q <= ~((read_i | write_i) & wait_q);
    end

    // read data, captured while the request waits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h0000_0000;
        else if (read_i & wait_q)
        begin
            rdata_q <= 32'h0000_0000;
            if (address_i == `PFM_CTRL_OFS)
                rdata_q <= {31'h0000_0000, loop_q};
            else if (address_i == `PFM_GPOUT_OFS)
                rdata_q <= {16'h0000, gpout_q};
            else if (address_i == `PFM_GPIN_OFS)
                rdata_q <= {16'h0000, gpin_q};
            else if (address_i == `PFM_ADDR_OFS)
                rdata_q <= {16'h0000, off_b_q, off_a_q, init_done_o, addr_q};
            else if (address_i == `PFM_CFG_OFS)
                rdata_q <= cfg_q;
            else if (rpin != `PFM_NO_PIN)
                rdata_q <= {24'h00_0000, pcfg_q[rpin]};
        end
    end

    // control and gpio output registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            loop_q <= 1'b0;
            gpout_q <= 16'h0000;
        end
        else if (wr_en && address_i == `PFM_CTRL_OFS)
            loop_q <= writedata_i[0];
        else if (wr_en && address_i == `PFM_GPOUT_OFS)
            gpout_q <= writedata_i[15:0];
    end

    // per-pin function select and io config; lock holds until reset
    generate
        for (genvar p = 0; p < NPINS; p++)
        begin : g_pcfg
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    pcfg_q[p] <= `PFM_PIN_RST;
                else if (wr_en && wpin == 5'(p) && !pcfg_q[p][`PFM_PC_LOCK])
                    pcfg_q[p] <= writedata_i[7:0];
            end
            assign {fn[p], gidx[p]} = fmap(5'(p), pcfg_q[p][`PFM_PC_FUNC]);
            pfm_pin_cell u_cell (
                .fn_i(fn[p]),
                .idx_i(gidx[p]),
                .dir_i(pcfg_q[p][`PFM_PC_DIR]),
                .od_i(pcfg_q[p][`PFM_PC_OD]),
                .gpa_i(gpout_q[7:0]),
                .gpb_i(gpout_q[15:8]),
                .native_out_i(native_out_i[p]),
                .native_oe_i(native_oe_i[p]),
                .sync_out_i(sync_out_i),
                .sync_oe_i(sync_oe_i),
                .fan_a_i(fan_a_drive_i),
                .fan_b_i(fan_b_drive_i),
                .auxd_oe_i(aux_twowire_data_oe_i),
                .auxc_oe_i(aux_twowire_clk_oe_i),
                .tx_i(tx_pin),
                .out_o(cell_out[p]),
                .oe_o(cell_oe[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // input routing: scan high to low so the lowest pin wins
    always_comb
    begin
        gp_in_d = 16'h0000;
        sync_d = 1'b0;
        tach_a_d = 1'b0;
        tach_b_d = 1'b0;
        auxd_d = 1'b1;
        auxc_d = 1'b1;
        rx_d = 1'b1;
        for (int p = NPINS - 1; p >= 0; p--)
        begin
            unique case (pfm_pkg::pfm_fn_t'(fn[p]))
                pfm_pkg::PFM_FN_GPA: gp_in_d[{1'b0, gidx[p]}] = pin_in_i[p];
                pfm_pkg::PFM_FN_GPB: gp_in_d[{1'b1, gidx[p]}] = pin_in_i[p];
                pfm_pkg::PFM_FN_SYNC: sync_d = pin_in_i[p];
                pfm_pkg::PFM_FN_FANA_TACH: tach_a_d = pin_in_i[p];
                pfm_pkg::PFM_FN_FANB_TACH: tach_b_d = pin_in_i[p];
                pfm_pkg::PFM_FN_AUXD: auxd_d = pin_in_i[p];
                pfm_pkg::PFM_FN_AUXC: auxc_d = pin_in_i[p];
                pfm_pkg::PFM_FN_URX: rx_d = pin_in_i[p];
                default: ;
            endcase
        end
    end

    // registered pin and peripheral outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pull_up_o <= '0;
            pull_dn_o <= '0;
            native_in_o <= '0;
            gpin_q <= 16'h0000;
            sync_in_o <= 1'b0;
            fan_a_speed_in_o <= 1'b0;
            fan_b_speed_in_o <= 1'b0;
            aux_twowire_data_o <= 1'b1;
            aux_twowire_clk_o <= 1'b1;
            serial_rx_in_o <= 1'b1;
        end
        else
        begin
            pin_out_o <= cell_out;
            pin_oe_o <= cell_oe;
            for (int p = 0; p < NPINS; p++)
            begin
                pull_up_o[p] <= pcfg_q[p][`PFM_PC_PU] & ~cell_oe[p];
                pull_dn_o[p] <= pcfg_q[p][`PFM_PC_PD] & ~cell_oe[p] & ~pcfg_q[p][`PFM_PC_PU];
            end
            native_in_o <= pin_in_i;
            gpin_q <= gp_in_d;
            sync_in_o <= sync_d;
            fan_a_speed_in_o <= tach_a_d;
            fan_b_speed_in_o <= tach_b_d;
            aux_twowire_data_o <= auxd_d;
            aux_twowire_clk_o <= auxc_d;
            serial_rx_in_o <= loop_q ? serial_tx_out_i : rx_d;
        end
    end
    assign gp_port_a_o = gpin_q[7:0];
    assign gp_port_b_o = gpin_q[15:8];

    ////////////////////////////////////////////////////////////////////////
    pfm_strap_decode u_dec (
        .res_i(strap_res_i),
        .lvl8_i(cfg_q[`PFM_CF_LVL8]),
        .offset_o(dec_off)
    );

    // initialization: load configuration, measure straps once, then run
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= pfm_pkg::PFM_ST_LOAD;
            cfg_q <= 32'h0000_0000;
            off_a_q <= 4'h0;
            off_b_q <= 4'h0;
            req_q <= 1'b0;
            src_q <= 2'b00;
        end
        else
        begin
            unique case (st_q)
                pfm_pkg::PFM_ST_LOAD:
                begin
                    cfg_q <= bus_firmware_config_cmd_i;
                    if (bus_firmware_config_cmd_i[`PFM_CF_STRAP_EN])
                    begin
                        st_q <= pfm_pkg::PFM_ST_MEAS_A;
                        req_q <= 1'b1;
                        src_q <= 2'b00;
                    end
                    else
                        st_q <= pfm_pkg::PFM_ST_RUN;
                end
                pfm_pkg::PFM_ST_MEAS_A:
                begin
                    if (strap_done_i)
                    begin
                        off_a_q <= dec_off;
                        if (cfg_q[`PFM_CF_TWO] | cfg_q[`PFM_CF_CURRENT_MONITOR_PIN])
                        begin
                            st_q <= pfm_pkg::PFM_ST_MEAS_B;
                            src_q <= cfg_q[`PFM_CF_TWO] ? 2'b01 : 2'b10;
                        end
                        else
                        begin
                            st_q <= pfm_pkg::PFM_ST_RUN;
                            req_q <= 1'b0;
                        end
                    end
                end
                pfm_pkg::PFM_ST_MEAS_B:
                begin
                    if (strap_done_i)
                    begin
                        off_b_q <= dec_off;
                        st_q <= pfm_pkg::PFM_ST_RUN;
                        req_q <= 1'b0;
                    end
                end
                pfm_pkg::PFM_ST_RUN: st_q <= pfm_pkg::PFM_ST_RUN;
            endcase
        end
    end
    assign strap_req_o = req_q;
    assign strap_src_o = src_q;

    // final address: base plus configured or strap offset, frozen after init
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            addr_q <= 7'h00;
        else if (st_q == pfm_pkg::PFM_ST_RUN)
            addr_q <= cfg_q[`PFM_CF_BASE] + (cfg_q[`PFM_CF_STRAP_EN] ?
                {off_b_q[2:0], off_a_q} : cfg_q[`PFM_CF_OFS]);
    end
    assign dev_addr_o = addr_q;

    // init done from a flop, rises together with the first address load
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            init_done_o <= 1'b0;
        else
            init_done_o <= (st_q == pfm_pkg::PFM_ST_RUN);
    end
    assign bus_rate_o = cfg_q[`PFM_CF_RATE];
    assign readdata_o = rdata_q;
    assign waitrequest_o = wait_q;
endmodule
`default_nettype wire

// [verification/pfm_properties.sv]
// pfm_properties: port checks of the pin mux top
// assumes: bound into pfm_top, one clock domain
`default_nettype none
module pfm_properties #(parameter int NPINS = 21) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic waitrequest_o,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic [NPINS-1:0] pull_up_o,
    input wire logic [NPINS-1:0] pull_dn_o,
    input wire logic strap_req_o,
    input wire logic init_done_o,
    input wire logic [6:0] dev_addr_o,
    input wire logic [1:0] bus_rate_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus handshake: one wait cycle, then a single answer cycle
    a_bus_answer: assert property ($rose(read_i || write_i) |=> !waitrequest_o)
        else $error("bus answer late");
    a_bus_release: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("wait stuck low");
    // pulls only on pins not driven, never both
    a_pull_drive: assert property ((pin_oe_o & (pull_up_o | pull_dn_o)) == '0)
        else $error("pull while driving");
    a_pull_excl: assert property ((pull_up_o & pull_dn_o) == '0)
        else $error("both pulls on");
    // straps measured only while initializing
    a_strap_init: assert property (init_done_o |-> !strap_req_o)
        else $error("strap measured at run");
    a_init_hold: assert property (init_done_o |=> init_done_o)
        else $error("init done dropped");
    a_addr_frozen: assert property (init_done_o && $past(init_done_o, 2) |-> $stable(dev_addr_o))
        else $error("address moved at run");
    a_rate_legal: assert property (bus_rate_o != 2'b11)
        else $error("bad bus rate");
endmodule
bind pfm_top pfm_properties #(.NPINS(NPINS)) u_pfm_props (.clk_i, .rst_i, .read_i, .write_i, .waitrequest_o,
    .pin_oe_o, .pull_up_o, .pull_dn_o, .strap_req_o, .init_done_o, .dev_addr_o, .bus_rate_o);
`default_nettype wire

// [verification/pfm_board_model.sv]
// pfm_board_model: strap resistors behind the measurement engine
// assumes: request is a level, one answer per selected strap
`default_nettype none
module pfm_board_model #(parameter int DELAY = 4) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic strap_req_i,
    input wire logic [1:0] strap_src_i,
    input wire logic [15:0] res_a_i,
    input wire logic [15:0] res_b_i,
    output logic strap_done_o,
    output logic [15:0] strap_res_o
);
    logic [7:0] cnt_q;
    // one pulse per reading; value lines toggle outside the pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !strap_req_i || strap_done_o)
        begin
            cnt_q <= 8'h00;
            strap_done_o <= 1'b0;
            strap_res_o <= rst_i ? 16'h5A5A : ~strap_res_o;
        end
        else if (cnt_q == 8'(DELAY))
        begin
            strap_done_o <= 1'b1;
            strap_res_o <= (strap_src_i == 2'b00) ? res_a_i : res_b_i;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            strap_res_o <= ~strap_res_o;
        end
    end
endmodule
`default_nettype wire

// [verification/pfm_top_tb_top.sv]
// pfm_top_tb_top: address select and pin routing scenarios
// assumes: pfm_top with 21 pins, board model on strap lines
`default_nettype none
module pfm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, read_i = 0, write_i = 0, waitrequest_o, strap_req_o, strap_done_i, init_done_o;
    logic sync_out_i = 0, sync_oe_i = 0, sync_in_o, fan_a_drive_i = 0, fan_b_drive_i = 0, fan_a_speed_in_o;
    logic fan_b_speed_in_o, aux_twowire_data_oe_i = 0, aux_twowire_clk_oe_i = 0, aux_twowire_data_o;
    logic aux_twowire_clk_o, serial_tx_out_i = 0, serial_rx_in_o;
    logic [7:0] address_i = 0, gp_port_a_o, gp_port_b_o;
    logic [31:0] writedata_i = 0, readdata_o, bus_firmware_config_cmd_i = 0, q;
    logic [20:0] pin_in_i, pin_out_o, pin_oe_o, pull_up_o, pull_dn_o, native_in_o, ext = '1;
    logic [20:0] native_out_i = 0, native_oe_i = 0;
    logic [15:0] strap_res_i, res_a = 0, res_b = 0;
    logic [1:0] strap_src_o, bus_rate_o;
    logic [6:0] dev_addr_o;
    int error_cnt = 0, checks = 0;
    localparam logic [31:0] CFG [7] = '{32'h0008_02A0, 32'h0000_4020, 32'h0004_4020, 32'h0000_C020,
        32'h0000_C020, 32'h0001_4020, 32'h0002_4020};
    localparam logic [15:0] RA [7] = '{16'h0000, 16'h004E, 16'hFFFF, 16'h0078, 16'h0708, 16'h004E, 16'h004E};
    localparam logic [15:0] RB [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0320, 16'h03FC};
    localparam logic [8:0] EXP [7] = '{9'h125, 9'h02F, 9'h0A0, 9'h027, 9'h021, 9'h01F, 9'h00F};
    // a driven pin reads back its own level
    assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & ext);
    // 50 MHz clock
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    pfm_top dut (.clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
        .pin_in_i, .pin_out_o, .pin_oe_o, .pull_up_o, .pull_dn_o, .native_out_i, .native_oe_i, .native_in_o,
        .gp_port_a_o, .gp_port_b_o, .sync_out_i, .sync_oe_i, .sync_in_o, .fan_a_drive_i, .fan_b_drive_i,
        .fan_a_speed_in_o, .fan_b_speed_in_o, .aux_twowire_data_oe_i, .aux_twowire_clk_oe_i,
        .aux_twowire_data_o, .aux_twowire_clk_o, .serial_tx_out_i, .serial_rx_in_o, .bus_firmware_config_cmd_i,
        .strap_req_o, .strap_src_o, .strap_done_i, .strap_res_i, .dev_addr_o, .bus_rate_o, .init_done_o);
    pfm_board_model brd (.clk_i, .rst_i, .strap_req_i(strap_req_o), .strap_src_i(strap_src_o), .res_a_i(res_a),
        .res_b_i(res_b), .strap_done_o(strap_done_i), .strap_res_o(strap_res_i));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // one bus access; request held until wait is sampled low at a rising edge
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address_i <= a;
        writedata_i <= d;
        read_i <= !we;
        write_i <= we;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 50);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 50)
        begin
            error_cnt++;
            summarize();
        end
    endtask
    task automatic pin(input int p, input logic [7:0] c);
        bus(1'b1, 8'(8'h40 + 4 * p), 32'(c));
        repeat (3) @(posedge clk_i);
    endtask
    // power cycle with a new configuration word and strap set
    task automatic boot(input int i);
        int n;
        rst_i <= 1'b1;
        bus_firmware_config_cmd_i <= CFG[i];
        res_a <= RA[i];
        res_b <= RB[i];
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        n = 0;
        do @(posedge clk_i) n++; while (init_done_o !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            error_cnt++;
            summarize();
        end
        repeat (2) @(posedge clk_i);
        chk("addr", 32'(EXP[i]), 32'({bus_rate_o, dev_addr_o}));
    endtask
    initial
    begin
        for (int i = 0; i < 7; i++)
            boot(i);
        res_a <= 16'h0708;
        repeat (20) @(posedge clk_i);
        chk("addr", 32'h0000_000F, 32'(dev_addr_o));
        bus(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        $display("address tests done");
        sync_oe_i <= 1'b1;
        sync_out_i <= 1'b1;
        pin(5, 8'h03);
        chk("sync out", 32'h0000_0003, {pin_oe_o[5], pin_out_o[5]});
        sync_oe_i <= 1'b0;
        ext[4:3] <= 2'b10;
        pin(3, 8'h03);
        pin(4, 8'h03);
        chk("sync in", 32'h0000_0000, 32'(sync_in_o));
        ext[4:3] <= 2'b01;
        repeat (3) @(posedge clk_i);
        chk("sync in", 32'h0000_0001, 32'(sync_in_o));
        pin(10, 8'h0F);
        chk("code 7", 32'h0000_0000, 32'(pin_oe_o[10]));
        pin(10, 8'h04);
        chk("tx", 32'h0000_0002, {pin_oe_o[10], pin_out_o[10]});
        ext[9] <= 1'b0;
        pin(9, 8'h04);
        chk("rx", 32'h0000_0000, 32'(serial_rx_in_o));
        serial_tx_out_i <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("loop", 32'h0000_0001, 32'(serial_rx_in_o));
        bus(1'b0, 8'h00, 32'h0000_0000);
        chk("ctrl", 32'h0000_0001, q);
        $display("routing tests done");
        bus(1'b1, 8'h04, 32'h0000_0080);
        pin(6, 8'h09);
        chk("gp out", 32'h0000_0003, {pin_oe_o[6], pin_out_o[6]});
        pin(6, 8'h19);
        chk("gp od", 32'h0000_0000, 32'(pin_oe_o[6]));
        ext[6] <= 1'b0;
        pin(6, 8'h21);
        chk("gp in", 32'h0000_0002, {pull_up_o[6], gp_port_a_o[7]});
        pin(6, 8'hA1);
        pin(6, 8'h03);
        bus(1'b0, 8'h58, 32'h0000_0000);
        chk("lock", 32'h0000_00A1, q);
        fan_a_drive_i <= 1'b1;
        pin(3, 8'h04);
        chk("fan pwm", 32'h0000_0003, {pin_oe_o[3], pin_out_o[3]});
        pin(7, 8'h41);
        chk("pull dn", 32'h0000_0001, 32'(pull_dn_o[7]));
        $display("gpio tests done");
        summarize();
    end
    // hang guard
    initial
    begin
        repeat (90000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
